// file: design/rws_defines.svh
// Constants of the reset and watchdog supervisor
`ifndef RWS_DEFINES_SVH
`define RWS_DEFINES_SVH
// =====================================================
// Timing
`define RWS_HCLK_NS      40
`define RWS_TICK_NS      1000
`define RWS_TICK_CYC     (`RWS_TICK_NS / `RWS_HCLK_NS)
`define RWS_SVC_TICKS    3
`define RWS_OPEN_WIN_MS  200
`define RWS_CLOSED_PCT   60
`define RWS_PER0_MS      10
`define RWS_PER1_MS      20
`define RWS_PER2_MS      50
`define RWS_PER3_MS      100
`define RWS_PER4_MS      200
`define RWS_PER5_MS      500
`define RWS_PER6_MS      1000
`define RWS_PER7_MS      10000
// =====================================================
// Serial frame and serial registers
`define RWS_SPI_BITS     16
`define RWS_SA_MS_CTRL   7'h01
`define RWS_SA_WATCHDOG_CONTROL_REGISTER   7'h03
`define RWS_SA_WK_CTRL0  7'h04
`define RWS_DEF_MS_CTRL  8'h00
`define RWS_DEF_WATCHDOG_CONTROL_REGISTER  8'h00
`define RWS_DEF_WK_CTRL0 8'h00
`define RWS_WD_WMASK     8'hF7
`define RWS_WD_STEP1     6
`define RWS_WATCHDOG_WINDOW_SELECT       5
`define RWS_WK_STEP0     6
`define RWS_MS_RDSEL     5
`define RWS_MS_SRSEL     4
`define RWS_CMD_NORMAL   2'h0
`define RWS_CMD_SLEEP    2'h1
`define RWS_CMD_STOP     2'h2
`define RWS_CMD_SOFT     2'h3
// =====================================================
// Bus register map
`define RWS_A_STATUS     32'h00000000
`define RWS_A_WATCHDOG_CONTROL_REGISTER    32'h00000004
`define RWS_A_MS_CTRL    32'h00000008
`define RWS_A_WK_CTRL0   32'h0000000C
`define RWS_A_CLEAR      32'h00000010
`define RWS_CLR_SPIFAIL  0
`endif

// file: design/rws_pkg.sv
// Types of the reset and watchdog supervisor
package rws_pkg;
  typedef enum logic [2:0] {
    RWS_INIT     = 3'h0,
    RWS_NORMAL   = 3'h1,
    RWS_STOP     = 3'h3,
    RWS_SLEEP    = 3'h2,
    RWS_RESTART  = 3'h6,
    RWS_FAILSAFE = 3'h7
  } rws_mode_t;
  typedef enum logic [1:0] {
    RWS_WD_OFF    = 2'h0,
    RWS_WD_LONG   = 2'h1,
    RWS_WD_CLOSED = 2'h3,
    RWS_WD_OPEN   = 2'h2
  } rws_wd_t;
endpackage : rws_pkg

// file: design/rws_supervisor.sv
// Reset output generator and SPI-served watchdog with an AHB-Lite status port
//
// Functional notes
// - Reset event pulls reset low after filter; held until event gone and delay done.
// - Release delay is long by default, short when reset_delay_select set.
// - At power-up reset stays low; released long delay after supply good.
// - Mode command 11 is soft reset: back to Init, serial registers defaulted.
// - Soft reset pulses reset with long delay unless soft_reset_pulse_select set.
// - Soft reset command ignored outside Normal and Stop.
// - Time-out or window watchdog by watchdog_window_select; time-out after reset.
// - Watchdog configuration writable only in Normal, frozen in Stop.
// - Long open window after release in Init; off in Sleep and Restart.
// - Every valid watchdog_control_register write with watchdog on, or in Stop, services and restarts timer.
// - Service takes effect three internal ticks after chip select rises.
// - Long open window lasts 200 ms and accepts any valid service.
// - Period field selects 10 ms to 10000 ms, shared by both types.
// - Failure enters Restart or Fail-Safe, counts; release from Restart gives Normal, long window.
// - Development mode keeps watchdog off and never resets for it.
// - Fail count increments per failure, saturating at 01 or 10 by config.
// - Fail count cleared by service, Stop disable, Sleep; kept on watchdog Fail-Safe.
// - Time-out type: service anytime restarts period; expiry resets.
// - Window type: 60 percent closed window then open; service starts closed.
// - Window type: closed-window service or expiry resets.
// - Odd parity watchdog_control_register write is discarded and sets serial_error_flag; other registers skip parity.
// - Reserved bit 3 counts in parity but reads zero.
// - Stop disable needs step1 then step0 in Normal; order enforced.
// - Re-enable in Stop or return from Stop to Normal gives long window, clears steps.
//
// The register offsets and the AHB-Lite register port were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "rws_defines.svh"

module rws_supervisor
  import rws_pkg::*;
#(
  parameter int TICKS_PER_MS = 1000,
  parameter int LONG_DLY_US  = 10000,
  parameter int SHORT_DLY_US = 2000,
  parameter int FILTER_US    = 10
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic        hready,
  input  wire logic [31:0] hwdata,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial link from the microcontroller
  input  wire logic        csn,
  input  wire logic        sclk,
  input  wire logic        mosi,
  // Supply and test pins
  input  wire logic        vcc1_ok,
  input  wire logic        dev_mode_pin,
  // Supervision outputs
  output logic             reset_out_n,
  output logic      [2:0]  sbc_mode
);

  localparam int          TUS       = 1000 / `RWS_TICK_NS;
  localparam logic [23:0] LW_T      = 24'(`RWS_OPEN_WIN_MS * TICKS_PER_MS);
  localparam logic [23:0] LONG_T    = 24'(LONG_DLY_US * TUS);
  localparam logic [23:0] SHORT_T   = 24'(SHORT_DLY_US * TUS);
  localparam logic [23:0] FILT_T    = 24'(FILTER_US * TUS);
  localparam logic [4:0]  TICK_LAST = 5'(`RWS_TICK_CYC - 1);

  function automatic logic [23:0] per_t(input logic [2:0] s);
    int ms;
    case (s)
      3'h0:    ms = `RWS_PER0_MS;
      3'h1:    ms = `RWS_PER1_MS;
      3'h2:    ms = `RWS_PER2_MS;
      3'h3:    ms = `RWS_PER3_MS;
      3'h4:    ms = `RWS_PER4_MS;
      3'h5:    ms = `RWS_PER5_MS;
      3'h6:    ms = `RWS_PER6_MS;
      default: ms = `RWS_PER7_MS;
    endcase
    per_t = 24'(ms * TICKS_PER_MS);
  endfunction : per_t

  function automatic logic [23:0] closed_t(input logic [23:0] p);
    closed_t = 24'((32'(p) * `RWS_CLOSED_PCT) / 100);
  endfunction : closed_t

  // =====================================================
  // Synchronisers and internal tick
  logic [2:0]  csn_q;
  logic [2:0]  sclk_q;
  logic [1:0]  mosi_q;
  logic [1:0]  vok_q;
  logic [1:0]  dev_q;
  logic [4:0]  tick_cnt_r;
  logic        tick;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csn_q      <= 3'h7;
      sclk_q     <= 3'h0;
      mosi_q     <= 2'h0;
      vok_q      <= 2'h0;
      dev_q      <= 2'h0;
      tick_cnt_r <= 5'h00;
    end else begin
      csn_q      <= {csn_q[1:0], csn};
      sclk_q     <= {sclk_q[1:0], sclk};
      mosi_q     <= {mosi_q[0], mosi};
      vok_q      <= {vok_q[0], vcc1_ok};
      dev_q      <= {dev_q[0], dev_mode_pin};
      tick_cnt_r <= tick ? 5'h00 : tick_cnt_r + 5'h01;
    end
  end

  assign tick = (tick_cnt_r == TICK_LAST);

  // =====================================================
  // Serial frame receiver, mode 0, MSB first
  logic [15:0] shift_r;
  logic [4:0]  bits_r;
  logic        sclk_rise;
  logic        csn_rise;
  logic        frame_ok;

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign csn_rise  = csn_q[1] & ~csn_q[2];
  assign frame_ok  = csn_rise & (bits_r == 5'(`RWS_SPI_BITS)) & shift_r[15];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shift_r <= 16'h0000;
      bits_r  <= 5'h00;
    end else if (csn_q[1]) begin
      bits_r <= 5'h00;
    end else if (sclk_rise && bits_r != 5'(`RWS_SPI_BITS)) begin
      shift_r <= {shift_r[14:0], mosi_q[1]};
      bits_r  <= bits_r + 5'h01;
    end
  end

  // Command waits three ticks after chip select rises
  logic        pend_r;
  logic [1:0]  pcnt_r;
  logic [14:0] cmd_r;
  logic        exec;

  assign exec = pend_r & tick & (pcnt_r == 2'(`RWS_SVC_TICKS - 1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pend_r <= 1'b0;
      pcnt_r <= 2'h0;
      cmd_r  <= 15'h0000;
    end else if (frame_ok) begin
      pend_r <= 1'b1;
      pcnt_r <= 2'h0;
      cmd_r  <= shift_r[14:0];
    end else if (exec) begin
      pend_r <= 1'b0;
    end else if (pend_r && tick) begin
      pcnt_r <= pcnt_r + 2'h1;
    end
  end

  // =====================================================
  // Command decode
  rws_mode_t   mode_r;
  rws_mode_t   mode_nxt;
  rws_wd_t     wd_st_r;
  rws_wd_t     wd_st_nxt;
  logic [23:0] wd_cnt_r;
  logic [23:0] wd_cnt_nxt;
  logic [7:0]  watchdog_control_register_r;
  logic [7:0]  ms_r;
  logic [7:0]  wk0_r;
  logic [1:0]  fc_r;
  logic        spi_fail_r;
  logic        reset_out_n_r;
  logic [23:0] dly_cnt_r;
  logic        pwr_r;
  logic        uv_evt_r;
  logic [23:0] flt_cnt_r;

  wire [6:0]  wr_addr   = cmd_r[14:8];
  wire [7:0]  wr_data   = cmd_r[7:0];
  wire [1:0]  mcmd      = wr_data[7:6];
  wire        in_normal = (mode_r == RWS_NORMAL);
  wire        in_stop   = (mode_r == RWS_STOP);
  wire        in_init   = (mode_r == RWS_INIT);
  wire        cmd_mode  = reset_out_n_r & (in_normal | in_stop | in_init);
  wire        wd_wr     = exec & (wr_addr == `RWS_SA_WATCHDOG_CONTROL_REGISTER);
  wire        ms_wr     = exec & (wr_addr == `RWS_SA_MS_CTRL) & cmd_mode;
  wire        wk_wr     = exec & (wr_addr == `RWS_SA_WK_CTRL0) & reset_out_n_r & in_normal;
  wire        par_ok    = ~^wr_data;
  wire        wd_on     = (wd_st_r != RWS_WD_OFF);
  wire        svc_ok    = wd_wr & par_ok & reset_out_n_r & ~dev_q[1] & (wd_on | in_stop);
  wire        cfg_wr    = wd_wr & par_ok & reset_out_n_r & in_normal;
  wire        closed_hit = svc_ok & (wd_st_r == RWS_WD_CLOSED);
  wire        cnt_zero  = tick & (wd_cnt_r == 24'h000000);
  wire        expire    = cnt_zero & ((wd_st_r == RWS_WD_LONG) | (wd_st_r == RWS_WD_OPEN));
  wire        watchdog_fail_count   = ~dev_q[1] & (closed_hit | expire);
  wire        step1     = watchdog_control_register_r[`RWS_WD_STEP1];
  wire        step0     = wk0_r[`RWS_WK_STEP0];
  wire        soft_go   = ms_wr & (mcmd == `RWS_CMD_SOFT) & (in_normal | in_stop);
  wire        go_normal = ms_wr & (mcmd == `RWS_CMD_NORMAL);
  wire        go_sleep  = ms_wr & (mcmd == `RWS_CMD_SLEEP);
  wire        go_stop   = ms_wr & (mcmd == `RWS_CMD_STOP) & in_normal;
  wire        stop_off  = go_stop & step0 & step1;
  wire        wake_wd   = in_stop & ((svc_ok & ~wd_on) | go_normal);
  wire        rst_go    = watchdog_fail_count | (soft_go & ~ms_r[`RWS_MS_SRSEL]);
  wire        rst_rel   = ~reset_out_n_r & (dly_cnt_r == 24'h000000) & ~uv_evt_r & ~rst_go;
  wire [23:0] dly_ld    = (pwr_r | soft_go | ~ms_r[`RWS_MS_RDSEL]) ? LONG_T : SHORT_T;
  wire [7:0]  wd_new    = in_normal ? (wr_data & `RWS_WD_WMASK) : watchdog_control_register_r;
  wire [23:0] per_new   = per_t(wd_new[2:0]);
  wire [23:0] per_cur   = per_t(watchdog_control_register_r[2:0]);
  wire [23:0] open_cur  = per_cur - closed_t(per_cur);
  wire [1:0]  fc_max    = (ms_r[1:0] == 2'h1) ? 2'h1 : 2'h2;

  // =====================================================
  // Reset output generator
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flt_cnt_r <= 24'h000000;
      uv_evt_r  <= 1'b0;
    end else if (vok_q[1]) begin
      flt_cnt_r <= 24'h000000;
      uv_evt_r  <= 1'b0;
    end else if (flt_cnt_r == FILT_T) begin
      uv_evt_r  <= 1'b1;
    end else if (tick) begin
      flt_cnt_r <= flt_cnt_r + 24'h000001;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      reset_out_n_r    <= 1'b0;
      dly_cnt_r <= LONG_T;
      pwr_r     <= 1'b1;
    end else if (uv_evt_r || rst_go) begin
      reset_out_n_r    <= 1'b0;
      dly_cnt_r <= dly_ld;
    end else if (rst_rel) begin
      reset_out_n_r    <= 1'b1;
      pwr_r     <= 1'b0;
    end else if (!reset_out_n_r && tick) begin
      dly_cnt_r <= dly_cnt_r - 24'h000001;
    end
  end

  // =====================================================
  // Mode and watchdog sequencing
  always_comb begin
    mode_nxt   = mode_r;
    wd_st_nxt  = wd_st_r;
    wd_cnt_nxt = (tick && wd_cnt_r != 24'h000000) ? wd_cnt_r - 24'h000001 : wd_cnt_r;
    if (watchdog_fail_count) begin
      mode_nxt  = ms_r[0] ? RWS_FAILSAFE : RWS_RESTART;
      wd_st_nxt = RWS_WD_OFF;
    end else if (soft_go) begin
      mode_nxt   = RWS_INIT;
      wd_st_nxt  = ms_r[`RWS_MS_SRSEL] ? RWS_WD_LONG : RWS_WD_OFF;
      wd_cnt_nxt = LW_T;
    end else if (rst_rel) begin
      mode_nxt   = (mode_r == RWS_RESTART) ? RWS_NORMAL : mode_r;
      wd_st_nxt  = (mode_r == RWS_FAILSAFE) ? RWS_WD_OFF : RWS_WD_LONG;
      wd_cnt_nxt = LW_T;
    end else if (!reset_out_n_r) begin
      wd_st_nxt = RWS_WD_OFF;
    end else if (go_sleep) begin
      mode_nxt  = RWS_SLEEP;
      wd_st_nxt = RWS_WD_OFF;
    end else if (go_stop) begin
      mode_nxt  = RWS_STOP;
      wd_st_nxt = stop_off ? RWS_WD_OFF : wd_st_r;
    end else if (wake_wd) begin
      mode_nxt   = go_normal ? RWS_NORMAL : mode_r;
      wd_st_nxt  = RWS_WD_LONG;
      wd_cnt_nxt = LW_T;
    end else if (go_normal) begin
      mode_nxt = RWS_NORMAL;
    end else if (svc_ok) begin
      wd_st_nxt  = wd_new[`RWS_WATCHDOG_WINDOW_SELECT] ? RWS_WD_CLOSED : RWS_WD_OPEN;
      wd_cnt_nxt = wd_new[`RWS_WATCHDOG_WINDOW_SELECT] ? closed_t(per_new) : per_new;
    end else if (cnt_zero && wd_st_r == RWS_WD_CLOSED) begin
      wd_st_nxt  = RWS_WD_OPEN;
      wd_cnt_nxt = open_cur;
    end
    if (dev_q[1]) begin
      wd_st_nxt = RWS_WD_OFF;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_r   <= RWS_INIT;
      wd_st_r  <= RWS_WD_OFF;
      wd_cnt_r <= 24'h000000;
    end else begin
      mode_r   <= mode_nxt;
      wd_st_r  <= wd_st_nxt;
      wd_cnt_r <= wd_cnt_nxt;
    end
  end

  // =====================================================
  // Serial registers and flags
  wire clr_fail;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      watchdog_control_register_r <= `RWS_DEF_WATCHDOG_CONTROL_REGISTER;
      ms_r      <= `RWS_DEF_MS_CTRL;
      wk0_r     <= `RWS_DEF_WK_CTRL0;
      fc_r      <= 2'h0;
    end else if (soft_go) begin
      watchdog_control_register_r <= `RWS_DEF_WATCHDOG_CONTROL_REGISTER;
      ms_r      <= `RWS_DEF_MS_CTRL;
      wk0_r     <= `RWS_DEF_WK_CTRL0;
      fc_r      <= 2'h0;
    end else begin
      if (cfg_wr) begin
        watchdog_control_register_r <= wr_data & `RWS_WD_WMASK;
      end else if (wake_wd) begin
        watchdog_control_register_r[`RWS_WD_STEP1] <= 1'b0;
      end
      if (wk_wr) begin
        wk0_r <= {wr_data[7], wr_data[6] & step1, wr_data[5:0]};
      end else if (wake_wd || (cfg_wr && wr_data[`RWS_WD_STEP1])) begin
        wk0_r[`RWS_WK_STEP0] <= 1'b0;
      end
      if (ms_wr && mcmd != `RWS_CMD_SOFT) begin
        ms_r <= wr_data;
      end
      if (watchdog_fail_count) begin
        fc_r <= (fc_r == fc_max) ? fc_r : fc_r + 2'h1;
      end else if (svc_ok || stop_off || go_sleep) begin
        fc_r <= 2'h0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      spi_fail_r <= 1'b0;
    end else begin
      spi_fail_r <= (wd_wr & ~par_ok) | (spi_fail_r & ~clr_fail & ~soft_go);
    end
  end

  // =====================================================
  // AHB-Lite slave, zero wait states
  logic        aw_r;
  logic [31:0] aaddr_r;

  wire        a_go  = hsel & htrans[1] & hready;
  wire [31:0] stat  = {23'h000000, reset_out_n_r, spi_fail_r, fc_r, wd_st_r, mode_r};
  wire [31:0] rd_mux =
    (haddr == `RWS_A_STATUS)   ? stat :
    (haddr == `RWS_A_WATCHDOG_CONTROL_REGISTER)  ? {24'h000000, watchdog_control_register_r} :
    (haddr == `RWS_A_MS_CTRL)  ? {24'h000000, ms_r} :
    (haddr == `RWS_A_WK_CTRL0) ? {24'h000000, wk0_r} : 32'h00000000;
  assign clr_fail = aw_r & (aaddr_r == `RWS_A_CLEAR) & hwdata[`RWS_CLR_SPIFAIL];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aw_r      <= 1'b0;
      aaddr_r   <= 32'h00000000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      aw_r      <= a_go & hwrite;
      aaddr_r   <= haddr;
      hrdata    <= (a_go && !hwrite) ? rd_mux : 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  assign reset_out_n = reset_out_n_r;
  assign sbc_mode    = mode_r;

  // =====================================================
  // Checks
  sequence s_frame_done;
    frame_ok;
  endsequence
  sequence s_in_stop;
    in_stop ##1 in_stop;
  endsequence

  a_rst_event_low: assert property (@(posedge hclk) disable iff (!hresetn)
    uv_evt_r |=> !reset_out_n_r ##1 !reset_out_n_r) else $error("reset high during supply event");
  a_rst_rel_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    $rose(reset_out_n_r) |-> $past(dly_cnt_r) == 24'h000000) else $error("reset released early");
  a_dly_short: assert property (@(posedge hclk) disable iff (!hresetn)
    (watchdog_fail_count && ms_r[`RWS_MS_RDSEL] && !pwr_r) |=> dly_cnt_r == SHORT_T) else $error("wrong short delay");
  a_soft_init: assert property (@(posedge hclk) disable iff (!hresetn)
    soft_go |=> mode_r == RWS_INIT && ms_r == `RWS_DEF_MS_CTRL) else $error("soft reset not to init");
  a_soft_pulse: assert property (@(posedge hclk) disable iff (!hresetn)
    (soft_go && !ms_r[`RWS_MS_SRSEL]) |=> !reset_out_n_r && dly_cnt_r == LONG_T) else $error("soft reset no pulse");
  a_soft_ignored: assert property (@(posedge hclk) disable iff (!hresetn)
    (exec && wr_addr == `RWS_SA_MS_CTRL && mcmd == `RWS_CMD_SOFT && !in_normal && !in_stop)
    |=> mode_r == $past(mode_r)) else $error("soft reset accepted in wrong mode");
  a_stop_cfg_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    s_in_stop |-> $stable(watchdog_control_register_r[5:0])) else $error("config changed in stop");
  a_svc_delay: assert property (@(posedge hclk) disable iff (!hresetn)
    s_frame_done |-> ##[50:76] exec) else $error("command not executed in time");
  a_parity_drop: assert property (@(posedge hclk) disable iff (!hresetn)
    (wd_wr && !par_ok) |=> spi_fail_r && $stable(watchdog_control_register_r) && $stable(wd_st_r)) else $error("bad parity used");
  a_fail_sat: assert property (@(posedge hclk) disable iff (!hresetn)
    fc_r <= fc_max || $changed(ms_r)) else $error("fail count above limit");
  a_dev_quiet: assert property (@(posedge hclk) disable iff (!hresetn)
    dev_q[1] |-> !watchdog_fail_count ##1 wd_st_r == RWS_WD_OFF) else $error("watchdog active in development");
  a_closed_reset: assert property (@(posedge hclk) disable iff (!hresetn)
    closed_hit |=> !reset_out_n_r && wd_st_r == RWS_WD_OFF) else $error("closed service not failed");

endmodule : rws_supervisor

`default_nettype wire

// file: verif/rws_mcu_model.sv
// Microcontroller model: SPI master that frames 16-bit writes toward the supervisor
`timescale 1ns/1ns
`default_nettype none

module rws_mcu_model (
  // Serial link toward the supervisor
  output var logic csn,
  output var logic sclk,
  output var logic mosi
);
  initial begin
    csn  = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
  end

  // ==========================================
  // One frame, MSB first, 320 ns link clock that stands still between frames
  task automatic send(input logic [15:0] f);
    csn <= 1'b0;
    #200;
    for (int i = 15; i >= 0; i--) begin
      mosi <= f[i];
      #160;
      sclk <= 1'b1;
      #160;
      sclk <= 1'b0;
    end
    #100;
    csn  <= 1'b1;
    mosi <= ~mosi;
    // Gap lets the command execute before anything else happens
    #4000;
  endtask : send
endmodule : rws_mcu_model

`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench of the reset and watchdog supervisor
`timescale 1ns/1ns
`default_nettype none
`include "rws_defines.svh"

module testbench;
  import rws_pkg::*;
  localparam int TPM   = 2;
  localparam int LONG  = 50;
  localparam int SHORT = 20;
  localparam int FILT  = 3;

  logic        hclk;
  logic        hresetn;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        csn;
  logic        sclk;
  logic        mosi;
  logic        vcc1_ok;
  logic        dev_mode_pin;
  logic        reset_out_n;
  logic [2:0]  sbc_mode;
  logic [31:0] s;
  logic [7:0]  d;
  logic [2:0]  p;
  int          n_errors;
  int          total_checks;

  rws_supervisor #(.TICKS_PER_MS(TPM), .LONG_DLY_US(LONG), .SHORT_DLY_US(SHORT), .FILTER_US(FILT))
  rws_supervisor_inst (
    .hclk(hclk), .hresetn(hresetn), .hsel(1'b1), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .csn(csn), .sclk(sclk), .mosi(mosi), .vcc1_ok(vcc1_ok),
    .dev_mode_pin(dev_mode_pin), .reset_out_n(reset_out_n), .sbc_mode(sbc_mode)
  );

  rws_mcu_model rws_mcu_model_inst (.csn(csn), .sclk(sclk), .mosi(mosi));

  always #20 hclk = ~hclk;

  // ==========================================
  // Expectations and bus helpers
  function automatic logic [7:0] par(input logic [7:0] v);
    return {^v[6:0], v[6:0]};
  endfunction : par

  function automatic int per(input logic [2:0] v);
    return (v == 3'h0 ? `RWS_PER0_MS : v == 3'h1 ? `RWS_PER1_MS : `RWS_PER2_MS) * TPM;
  endfunction : per

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic tk(input int n);
    repeat (n * `RWS_TICK_CYC) @(posedge hclk);
  endtask : tk

  task automatic ahb(input logic [31:0] a, input logic w, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    chk(hresp, 1'b0);
    rd = hrdata;
  endtask : ahb

  task automatic ser(input logic [6:0] a, input logic [7:0] v);
    rws_mcu_model_inst.send({1'b1, a, v});
  endtask : ser

  task automatic end_of_test;
    $display("checks=%0d errors=%0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_of_test

  initial begin
    #2_000_000;
    n_errors++;
    end_of_test();
  end

  // ==========================================
  // Main sequence
  initial begin
    hclk         = 1'b0;
    hresetn      = 1'b0;
    haddr        = 32'h0;
    htrans       = 2'h0;
    hwrite       = 1'b0;
    hwdata       = 32'h0;
    vcc1_ok      = 1'b1;
    dev_mode_pin = 1'b0;
    n_errors     = 0;
    total_checks = 0;
    void'($urandom(4794));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    tk(LONG - 5);
    chk(reset_out_n, 1'b0);
    tk(10);
    chk(reset_out_n, 1'b1);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[4:0], 5'h08);
    ser(`RWS_SA_MS_CTRL, 8'h00);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[4:0], 5'h09);
    // Odd parity write is dropped, then the flag is cleared
    ser(`RWS_SA_WATCHDOG_CONTROL_REGISTER, par(8'h0A) ^ 8'h80);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[7], 1'b1);
    ahb(`RWS_A_WATCHDOG_CONTROL_REGISTER, 1'b0, 32'h0, s);
    chk(s, 32'h0);
    ahb(`RWS_A_CLEAR, 1'b1, 32'h1, s);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[7], 1'b0);
    // Random time-out period with reserved bit set, left unserved
    p = 3'($urandom % 3);
    d = par({5'h01, p});
    ser(`RWS_SA_WATCHDOG_CONTROL_REGISTER, d);
    tk(per(p) - 3);
    chk(reset_out_n, 1'b1);
    tk(6);
    chk(reset_out_n, 1'b0);
    chk(sbc_mode, 3'h6);
    ahb(`RWS_A_WATCHDOG_CONTROL_REGISTER, 1'b0, 32'h0, s);
    chk(s[7:0], d & 8'hF7);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[6:0], 7'h26);
    tk(LONG - 8);
    chk(reset_out_n, 1'b0);
    tk(10);
    chk(reset_out_n, 1'b1);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[6:0], 7'h29);
    // Window type: a second service lands in the closed window
    ser(`RWS_SA_MS_CTRL, 8'h20);
    for (int i = 0; i < 2; i++) begin
      ser(`RWS_SA_WATCHDOG_CONTROL_REGISTER, par(8'h22));
      ser(`RWS_SA_WATCHDOG_CONTROL_REGISTER, par(8'h22));
      tk(SHORT - 6);
      chk(reset_out_n, 1'b0);
      tk(10);
      chk(reset_out_n, 1'b1);
      chk(sbc_mode, 3'h1);
      ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
      chk(s[6:5], 2'h1);
    end
    // Long open window runs out unserved: the count reaches its limit
    tk(`RWS_OPEN_WIN_MS * TPM + SHORT + 10);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[8:0], 9'h149);
    // Supply dip longer than the filter, checked before and after the filter time
    vcc1_ok <= 1'b0;
    tk(1);
    chk(reset_out_n, 1'b1);
    tk(5);
    chk(reset_out_n, 1'b0);
    vcc1_ok <= 1'b1;
    tk(SHORT + 6);
    chk(reset_out_n, 1'b1);
    // Soft reset with pulse, then ignored in Init
    ser(`RWS_SA_MS_CTRL, 8'h00);
    ser(`RWS_SA_MS_CTRL, 8'hC0);
    chk(reset_out_n, 1'b0);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[2:0], 3'h0);
    ahb(`RWS_A_WATCHDOG_CONTROL_REGISTER, 1'b0, 32'h0, s);
    chk(s, 32'h0);
    tk(LONG + 5);
    chk(reset_out_n, 1'b1);
    ser(`RWS_SA_MS_CTRL, 8'hC0);
    chk(reset_out_n, 1'b1);
    // Two-step disable for Stop, then a service in Stop wakes the watchdog
    ser(`RWS_SA_MS_CTRL, 8'h00);
    ser(`RWS_SA_WATCHDOG_CONTROL_REGISTER, par(8'h42));
    ser(`RWS_SA_WK_CTRL0, 8'h40);
    ser(`RWS_SA_MS_CTRL, 8'h80);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[6:0], 7'h03);
    ser(`RWS_SA_WATCHDOG_CONTROL_REGISTER, par(8'h25));
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[4:0], 5'h0B);
    ahb(`RWS_A_WATCHDOG_CONTROL_REGISTER, 1'b0, 32'h0, s);
    chk(s, 32'h02);
    ahb(`RWS_A_WK_CTRL0, 1'b0, 32'h0, s);
    chk(s, 32'h0);
    // Development mode: closed-window service gives no reset
    @(posedge hclk);
    dev_mode_pin <= 1'b1;
    ser(`RWS_SA_MS_CTRL, 8'h00);
    ser(`RWS_SA_WATCHDOG_CONTROL_REGISTER, par(8'h22));
    ser(`RWS_SA_WATCHDOG_CONTROL_REGISTER, par(8'h22));
    tk(5);
    chk(reset_out_n, 1'b1);
    // Sleep leaves the watchdog off
    ser(`RWS_SA_MS_CTRL, 8'h40);
    ahb(`RWS_A_STATUS, 1'b0, 32'h0, s);
    chk(s[4:0], 5'h02);
    chk(sbc_mode, 3'h2);
    end_of_test();
  end
endmodule : testbench

`default_nettype wire
